// *** design/tdg_gate_logic.sv ***
// top: register port, mode locks, interrupts and three phase timers
`timescale 1ns/1ps
module tdg_gate_logic #(
  parameter int unsigned NPH = tdg_pkg::PHASES,
  parameter int unsigned CW  = tdg_pkg::CNT_W
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic [NPH-1:0] phase_high_side_request_n,
  input  wire logic [NPH-1:0] phase_low_side_request,
  input  wire logic           drive_enable_first,
  input  wire logic           drive_enable_second,
  input  wire logic [3:0]     regAddr,
  input  wire logic [15:0]    regWdata,
  input  wire logic           regWr,
  input  wire logic           regRd,
  output logic      [15:0]    regRdata,
  output logic      [NPH-1:0] highGate,
  output logic      [NPH-1:0] lowGate,
  output logic      [NPH-1:0] lowCurrentBlank,
  output logic                irq
);
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: three stages, change counts when 2nd and 3rd agree
  localparam int unsigned SW = 2 * NPH + 2;
  logic [SW-1:0] syncA_r, syncB_r, syncC_r, clean_r;
  logic [SW-1:0] rawIn;

  assign rawIn = {drive_enable_second, drive_enable_first,
                  phase_low_side_request, phase_high_side_request_n};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_r <= {{2{1'b0}}, {NPH{1'b0}}, {NPH{1'b1}}};
      syncB_r <= {{2{1'b0}}, {NPH{1'b0}}, {NPH{1'b1}}};
      syncC_r <= {{2{1'b0}}, {NPH{1'b0}}, {NPH{1'b1}}};
    end else begin
      syncA_r <= rawIn;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clean_r <= {{2{1'b0}}, {NPH{1'b0}}, {NPH{1'b1}}};
    end else begin
      for (int i = 0; i < SW; i++) begin
        if (syncB_r[i] == syncC_r[i]) begin
          clean_r[i] <= syncC_r[i];
        end
      end
    end
  end

  logic           enable;
  logic [NPH-1:0] hsReqN, lsReq;
  assign hsReqN = clean_r[NPH-1:0];
  assign lsReq  = clean_r[2*NPH-1:NPH];
  assign enable = clean_r[2*NPH] & clean_r[2*NPH+1];

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [tdg_pkg::CTRL_W-1:0] ctrl_r;
  logic [15:0]                dtSteps_r;
  logic [15:0]                stepCyc_r;
  logic                       simul_r;
  logic                       simulUsed_r;
  tdg_pkg::tdg_unlock_t       unlock_r;
  logic [tdg_pkg::IRQ_W-1:0]  irqStat_r, irqMask_r;
  logic                       wrCtrl, wrDt, wrCal, wrSim;

  assign wrCtrl = regWr && regAddr == tdg_pkg::ADDR_CTRL;
  assign wrDt   = regWr && regAddr == tdg_pkg::ADDR_DEADTIME;
  assign wrCal  = regWr && regAddr == tdg_pkg::ADDR_CAL;
  assign wrSim  = regWr && regAddr == tdg_pkg::ADDR_SIMUL;

  // modes stay fixed once the lock bit is written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= '0;
    end else if (wrCtrl && !ctrl_r[tdg_pkg::CTRL_LOCK]) begin
      ctrl_r <= regWdata[tdg_pkg::CTRL_W-1:0];
    end
  end

  // steps above the 12 us ceiling saturate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dtSteps_r <= '0;
      stepCyc_r <= 16'(tdg_pkg::STEP_CYC_NOM);
    end else begin
      if (wrDt) begin
        dtSteps_r <= (regWdata > 16'(tdg_pkg::DT_MAX_STEPS)) ?
                     16'(tdg_pkg::DT_MAX_STEPS) : regWdata;
      end
      if (wrCal && regWdata != tdg_pkg::ZERO16) begin
        stepCyc_r <= regWdata;
      end
    end
  end

  // key 1, key 2, then one setting write; later attempts ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlock_r    <= tdg_pkg::TDG_UNLOCK_IDLE;
      simul_r     <= 1'b0;
      simulUsed_r <= 1'b0;
    end else if (wrSim && !simulUsed_r) begin
      unique case (unlock_r)
        tdg_pkg::TDG_UNLOCK_IDLE: begin
          unlock_r <= (regWdata == tdg_pkg::UNLOCK_KEY1) ?
                      tdg_pkg::TDG_UNLOCK_KEYED : tdg_pkg::TDG_UNLOCK_IDLE;
        end
        tdg_pkg::TDG_UNLOCK_KEYED: begin
          unlock_r <= (regWdata == tdg_pkg::UNLOCK_KEY2) ?
                      tdg_pkg::TDG_UNLOCK_DONE : tdg_pkg::TDG_UNLOCK_IDLE;
        end
        tdg_pkg::TDG_UNLOCK_DONE: begin
          simul_r     <= regWdata[tdg_pkg::SIM_EN_BIT];
          simulUsed_r <= 1'b1;
          unlock_r    <= tdg_pkg::TDG_UNLOCK_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dead time in cycles: steps times calibrated step length
  logic [31:0]   dtProd;
  logic [CW-1:0] dtCycles;
  assign dtProd   = dtSteps_r * stepCyc_r;
  assign dtCycles = (ctrl_r[tdg_pkg::CTRL_ZERODT]) ? '0 :
                    (dtProd[31:CW] != '0) ? '1 : dtProd[CW-1:0];

  ////////////////////////////////////////////////////////////////////////
  // phases
  logic [NPH-1:0] hsRefused;

  genvar g;
  generate
    for (g = 0; g < NPH; g++) begin : gPhase
      tdg_phase #(.CW(CW)) uPhase (
        .clk       (clk),
        .rst_b     (rst_b),
        .hsReqN    (hsReqN[g]),
        .lsReq     (lsReq[g]),
        .enable    (enable),
        .dtCycles  (dtCycles),
        .simulMode (simul_r),
        .full_on_mode    (ctrl_r[tdg_pkg::CTRL_FULL_ON_MODE]),
        .hsGate    (highGate[g]),
        .lsGate    (lowGate[g]),
        .blanking  (lowCurrentBlank[g]),
        .hsRefused (hsRefused[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky events, write one to clear, set wins
  logic                      enPrev_r;
  logic [tdg_pkg::IRQ_W-1:0] irqEvt;
  logic [tdg_pkg::IRQ_W-1:0] irqClr;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enPrev_r <= 1'b0;
    end else begin
      enPrev_r <= enable;
    end
  end

  always_comb begin
    irqEvt = '0;
    irqEvt[tdg_pkg::IRQ_ENDROP]  = enPrev_r & ~enable;
    irqEvt[tdg_pkg::IRQ_HSREF]   = |hsRefused;
    irqEvt[tdg_pkg::IRQ_SIMREJ]  = wrSim & simulUsed_r;
    irqEvt[tdg_pkg::IRQ_LOCKREJ] = wrCtrl & ctrl_r[tdg_pkg::CTRL_LOCK];
  end

  assign irqClr = (regWr && regAddr == tdg_pkg::ADDR_IRQ_STAT) ?
                  regWdata[tdg_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_r <= '0;
      irqMask_r <= '0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
      if (regWr && regAddr == tdg_pkg::ADDR_IRQ_MASK) begin
        irqMask_r <= regWdata[tdg_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  ////////////////////////////////////////////////////////////////////////
  // read port: data valid the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= '0;
    end else if (!regRd) begin
      regRdata <= '0;
    end else begin
      unique case (regAddr)
        tdg_pkg::ADDR_CTRL:     regRdata <= 16'(ctrl_r);
        tdg_pkg::ADDR_DEADTIME: regRdata <= dtSteps_r;
        tdg_pkg::ADDR_CAL:      regRdata <= stepCyc_r;
        tdg_pkg::ADDR_SIMUL:    regRdata <= {7'h00, simul_r, 6'h00, simulUsed_r, unlock_r == tdg_pkg::TDG_UNLOCK_DONE};
        tdg_pkg::ADDR_STATUS:   regRdata <= 16'({enable, lowCurrentBlank, lowGate, highGate});
        tdg_pkg::ADDR_IRQ_STAT: regRdata <= 16'(irqStat_r);
        tdg_pkg::ADDR_IRQ_MASK: regRdata <= 16'(irqMask_r);
        tdg_pkg::ADDR_STATE:    regRdata <= 16'({lsReq, ~hsReqN});
        default:                regRdata <= '0;
      endcase
    end
  end
endmodule

// *** design/tdg_phase.sv ***
// one phase: edge detection, dead-time timer, blanking, bootstrap interlock
`timescale 1ns/1ps
module tdg_phase #(
  parameter int unsigned CW = tdg_pkg::CNT_W
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          hsReqN,
  input  wire logic          lsReq,
  input  wire logic          enable,
  input  wire logic [CW-1:0] dtCycles,
  input  wire logic          simulMode,
  input  wire logic          full_on_mode,
  output logic               hsGate,
  output logic               lsGate,
  output logic               blanking,
  output logic               hsRefused
);
  logic          hsReq;
  logic          hsPrev_r, lsPrev_r;
  logic          hsRise, lsRise;
  logic          hsPend_r, lsPend_r;
  logic [CW-1:0] dtCnt_r;
  logic [15:0]   blankCnt_r;
  logic          lsSeen_r;
  logic          hsOn_r, lsOn_r;

  assign hsReq  = ~hsReqN;
  assign hsRise = hsReq & ~hsPrev_r;
  assign lsRise = lsReq & ~lsPrev_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hsPrev_r <= 1'b0;
      lsPrev_r <= 1'b0;
    end else begin
      hsPrev_r <= hsReq;
      lsPrev_r <= lsReq;
    end
  end

  // timer starts on the opposite turn-off, which is the same edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hsOn_r   <= 1'b0;
      lsOn_r   <= 1'b0;
      hsPend_r <= 1'b0;
      lsPend_r <= 1'b0;
      dtCnt_r  <= '0;
    end else if (!enable) begin
      hsOn_r   <= 1'b0;
      lsOn_r   <= 1'b0;
      hsPend_r <= 1'b0;
      lsPend_r <= 1'b0;
      dtCnt_r  <= '0;
    end else if (simulMode) begin
      hsOn_r   <= hsReq & lsSeen_r;
      lsOn_r   <= lsReq;
      hsPend_r <= 1'b0;
      lsPend_r <= 1'b0;
    end else if (hsRise && (lsSeen_r || lsRise)) begin
      lsOn_r   <= 1'b0;
      hsOn_r   <= (dtCycles == '0);
      hsPend_r <= (dtCycles != '0);
      lsPend_r <= 1'b0;
      dtCnt_r  <= dtCycles;
    end else if (lsRise) begin
      hsOn_r   <= 1'b0;
      lsOn_r   <= (dtCycles == '0);
      lsPend_r <= (dtCycles != '0);
      hsPend_r <= 1'b0;
      dtCnt_r  <= dtCycles;
    end else begin
      if (!hsReq && !full_on_mode) begin
        hsOn_r   <= 1'b0;
        hsPend_r <= 1'b0;
      end
      if (!lsReq && !full_on_mode) begin
        lsOn_r   <= 1'b0;
        lsPend_r <= 1'b0;
      end
      if ((hsPend_r || lsPend_r) && dtCnt_r != '0) begin
        dtCnt_r <= dtCnt_r - 1'b1;
      end
      if (hsPend_r && dtCnt_r == CW'(1)) begin
        hsOn_r   <= 1'b1;
        hsPend_r <= 1'b0;
      end
      if (lsPend_r && dtCnt_r == CW'(1)) begin
        lsOn_r   <= 1'b1;
        lsPend_r <= 1'b0;
      end
    end
  end

  // bootstrap must be charged by one low-side pulse after enable unless low and high requests rise in the same cycle with simulMode off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lsSeen_r <= 1'b0;
    end else if (!enable) begin
      lsSeen_r <= 1'b0;
    end else if (lsOn_r) begin
      lsSeen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blankCnt_r <= '0;
    end else if (simulMode) begin
      blankCnt_r <= '0;
    end else if (hsReq != hsPrev_r || lsReq != lsPrev_r) begin
      blankCnt_r <= 16'(tdg_pkg::BLANK_CYC);
    end else if (blankCnt_r != '0) begin
      blankCnt_r <= blankCnt_r - 1'b1;
    end
  end

  assign blanking  = (blankCnt_r != '0);
  assign hsRefused = enable & hsRise & ~lsSeen_r & ~lsRise;
  assign hsGate    = hsOn_r & enable;
  assign lsGate    = lsOn_r & enable;
endmodule

// *** inc/tdg_pkg.sv ***
// package: constants and types for the three-phase dead-time gate logic
package tdg_pkg;
  localparam int unsigned CLK_FREQ_HZ    = 20_000_000;
  localparam int unsigned CLK_PERIOD_PS  = 50_000;
  localparam int unsigned STEP_NS        = 50;
  localparam int unsigned DT_MAX_NS      = 12_000;
  localparam int unsigned STEP_CYC_NOM   = (STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned DT_MAX_STEPS   = DT_MAX_NS / STEP_NS;
  localparam int unsigned BLANK_NS       = 1_000;
  localparam int unsigned BLANK_CYC      = ((BLANK_NS * 1000) / CLK_PERIOD_PS) > 0 ?
                                           ((BLANK_NS * 1000) / CLK_PERIOD_PS) : 1;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned PHASES         = 3;

  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_DEADTIME = 4'h1;
  localparam logic [3:0] ADDR_CAL      = 4'h2;
  localparam logic [3:0] ADDR_SIMUL    = 4'h3;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_STATE    = 4'h7;

  localparam logic [15:0] UNLOCK_KEY1  = 16'h00A5;
  localparam logic [15:0] UNLOCK_KEY2  = 16'h005A;

  localparam int unsigned CTRL_FULL_ON_MODE  = 0;
  localparam int unsigned CTRL_DESAT   = 1;
  localparam int unsigned CTRL_ZERODT  = 2;
  localparam int unsigned CTRL_LOCK    = 3;
  localparam int unsigned CTRL_W       = 4;
  localparam int unsigned SIM_EN_BIT   = 8;

  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_ENDROP   = 0;
  localparam int unsigned IRQ_HSREF    = 1;
  localparam int unsigned IRQ_SIMREJ   = 2;
  localparam int unsigned IRQ_LOCKREJ  = 3;

  localparam logic [15:0] ZERO16       = 16'h0000;

  typedef enum logic [1:0] {TDG_UNLOCK_IDLE, TDG_UNLOCK_KEYED, TDG_UNLOCK_DONE} tdg_unlock_t;
endpackage

// *** tb/tdg_gate_logic_checker.sv ***
// checker: port-level assertions for the gate logic top
`timescale 1ns/1ps
module tdg_gate_logic_checker #(
  parameter int unsigned NPH = 3
) (
  input wire logic           clk,
  input wire logic           rst_b,
  input wire logic [NPH-1:0] phase_high_side_request_n,
  input wire logic [NPH-1:0] phase_low_side_request,
  input wire logic           drive_enable_first,
  input wire logic           drive_enable_second,
  input wire logic           regRd,
  input wire logic [15:0]    regRdata,
  input wire logic [NPH-1:0] highGate,
  input wire logic [NPH-1:0] lowGate,
  input wire logic [NPH-1:0] lowCurrentBlank,
  input wire logic           irq
);
  logic [NPH-1:0] lowSeen_r;
  logic           enOk;
  assign enOk = drive_enable_first && drive_enable_second;
  // cleared at the pins, earlier than the design: conservative
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowSeen_r <= '0;
    end else if (!enOk) begin
      lowSeen_r <= '0;
    end else begin
      lowSeen_r <= lowSeen_r | lowGate;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  a_enable_gates_off: assert property ((!enOk)[*5] |-> highGate == '0 && lowGate == '0)
    else $error("gate on while disabled");
  a_no_overlap: assert property ((highGate & lowGate) == '0)
    else $error("both gates of a phase on");
  a_read_idle_zero: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside its cycle");
  a_low_rise_cause: assert property ($rose(lowGate[0]) |-> $past(phase_low_side_request[0], 3))
    else $error("low gate on without request");
  a_high_rise_cause: assert property ($rose(highGate[0]) |-> !$past(phase_high_side_request_n[0], 3))
    else $error("high gate on without request");
  a_high_after_low: assert property ((highGate & ~$past(highGate) & ~lowSeen_r) == '0)
    else $error("high gate before low pulse");
  a_opposite_off: assert property ($rose(phase_low_side_request[0]) |-> ##[1:6] !highGate[0])
    else $error("high gate not dropped");
  a_blank_on_change: assert property ($rose(phase_low_side_request[0]) && enOk |-> ##[1:8] lowCurrentBlank[0])
    else $error("no blanking after change");
  c_high_on: cover property ($rose(highGate[0]));
  c_irq_on: cover property ($rose(irq));
  c_blank_end: cover property ($fell(lowCurrentBlank[1]));
endmodule
bind tdg_gate_logic tdg_gate_logic_checker #(.NPH(NPH)) u_chk (.clk(clk), .rst_b(rst_b),
  .phase_high_side_request_n(phase_high_side_request_n), .phase_low_side_request(phase_low_side_request),
  .drive_enable_first(drive_enable_first), .drive_enable_second(drive_enable_second), .regRd(regRd),
  .regRdata(regRdata), .highGate(highGate), .lowGate(lowGate), .lowCurrentBlank(lowCurrentBlank), .irq(irq));

// *** tb/tdg_mcu_model.sv ***
// controller model: drives phase requests and enables
`timescale 1ns/1ps
module tdg_mcu_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       cmdGo,
  input  wire logic [1:0] cmdPhase,
  input  wire logic [1:0] cmdSide,
  input  wire logic       cmdForce,
  input  wire logic [1:0] enCmd,
  output logic      [2:0] hsReqN,
  output logic      [2:0] lsReq,
  output logic            enFirst,
  output logic            enSecond
);
  logic [2:0] charged_r;
  // side 0 idle, 1 low, 2 high; force skips the low-first habit on purpose
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hsReqN    <= 3'h7;
      lsReq     <= 3'h0;
      enFirst   <= 1'b0;
      enSecond  <= 1'b0;
      charged_r <= 3'h0;
    end else begin
      enFirst  <= enCmd[0];
      enSecond <= enCmd[1];
      if (enCmd != 2'h3) charged_r <= 3'h0;
      if (cmdGo) begin
        lsReq[cmdPhase] <= (cmdSide == 2'h1);
        if (cmdSide != 2'h2 || charged_r[cmdPhase] || cmdForce) hsReqN[cmdPhase] <= (cmdSide != 2'h2);
        if (cmdSide == 2'h1) charged_r[cmdPhase] <= 1'b1;
      end
    end
  end
endmodule

// *** tb/test_three_phase_deadtime_gate_logic.sv ***
// testbench: dead-time, enable, interrupt and mode-lock scenarios
`timescale 1ns/1ps
module test_three_phase_deadtime_gate_logic;
  logic        clk;
  logic        rst_b;
  logic [3:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  logic [2:0]  hsReqN;
  logic [2:0]  lsReq;
  logic        enFirst;
  logic        enSecond;
  logic [2:0]  highGate;
  logic [2:0]  lowGate;
  logic [2:0]  blank;
  logic        irq;
  logic        cmdGo;
  logic [1:0]  cmdPhase;
  logic [1:0]  cmdSide;
  logic        cmdForce;
  logic [1:0]  enCmd;
  logic [31:0] seed_r;
  int          failures;
  int          checkCount;
  tdg_gate_logic dut (.clk(clk), .rst_b(rst_b), .phase_high_side_request_n(hsReqN), .phase_low_side_request(lsReq),
    .drive_enable_first(enFirst), .drive_enable_second(enSecond), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .highGate(highGate), .lowGate(lowGate),
    .lowCurrentBlank(blank), .irq(irq));
  tdg_mcu_model u_mcu (.clk(clk), .rst_b(rst_b), .cmdGo(cmdGo), .cmdPhase(cmdPhase), .cmdSide(cmdSide),
    .cmdForce(cmdForce), .enCmd(enCmd), .hsReqN(hsReqN), .lsReq(lsReq), .enFirst(enFirst), .enSecond(enSecond));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // gap is steps times step length; zero means high rises as low falls
  function automatic logic [15:0] dead_gap(input int steps, input int cal, input logic zdt);
    int e;
    e = zdt ? 0 : steps * cal;
    return 16'(e);
  endfunction
  task automatic end_of_test();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp, input string what);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata & m, exp, what);
  endtask
  task automatic cmd(input int p, input logic [1:0] s, input logic f);
    @(posedge clk);
    cmdGo    <= 1'b1;
    cmdPhase <= 2'(p);
    cmdSide  <= s;
    cmdForce <= f;
    @(posedge clk);
    cmdGo <= 1'b0;
  endtask
  task automatic dead_test(input int p, input int steps, input int cal, input logic zdt);
    int q;
    int n;
    int gap;
    q = (p + 1) % 3;
    wr(tdg_pkg::ADDR_CTRL, {13'h0000, zdt, 2'h0});
    wr(tdg_pkg::ADDR_DEADTIME, 16'(steps));
    wr(tdg_pkg::ADDR_CAL, 16'(cal));
    cmd(q, 2'h1, 1'b0);
    cmd(p, 2'h1, 1'b0);
    tick(steps * cal + 40);
    chk({13'h0000, lowGate[p], lowGate[q], blank[p]}, 16'h0006, "low on");
    rd(tdg_pkg::ADDR_STATUS, 16'h03FF, 16'h0200 | 16'(8 << p) | 16'(8 << q), "status");
    cmd(p, 2'h2, 1'b0);
    n = 0;
    while (lowGate[p] === 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    gap = 0;
    while (highGate[p] !== 1'b1 && gap < 20000) begin
      tick(1);
      gap++;
    end
    if (n == 50 || gap == 20000) begin
      $display("BAD %0t wait expired", $time);
      failures++;
      end_of_test();
    end
    chk(16'(gap), dead_gap(steps, cal, zdt), "dead time");
    chk(16'(lowGate[q]), 16'h0001, "other phase");
    cmd(p, 2'h0, 1'b0);
    cmd(q, 2'h0, 1'b0);
    tick(steps * cal + 40);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    cmdGo = 1'b0;
    cmdPhase = 2'h0;
    cmdSide = 2'h0;
    cmdForce = 1'b0;
    enCmd = 2'h3;
    seed_r = 32'h0000B454;
    failures = 0;
    checkCount = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    tick(8);
    rd(tdg_pkg::ADDR_CAL, 16'hFFFF, 16'h0001, "cal reset");
    for (int a = 8; a < 16; a++) rd(4'(a), 16'hFFFF, 16'h0000, "unmapped");
    wr(tdg_pkg::ADDR_DEADTIME, 16'h012C);
    rd(tdg_pkg::ADDR_DEADTIME, 16'hFFFF, 16'(tdg_pkg::DT_MAX_STEPS), "saturate");
    wr(tdg_pkg::ADDR_CAL, 16'h0000);
    rd(tdg_pkg::ADDR_CAL, 16'hFFFF, 16'h0001, "cal zero");
    dead_test(0, 0, 1, 1'b0);
    dead_test(1, 240, 1, 1'b0);
    dead_test(2, 7, 3, 1'b0);
    dead_test(0, 20, 1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      seed_r = lfsr_next(seed_r);
      dead_test(int'(seed_r[1:0]) % 3, int'(seed_r[9:4]), 1 + int'(seed_r[12]), 1'b0);
    end
    $display("test dead time done");
    wr(tdg_pkg::ADDR_IRQ_STAT, 16'h000F);
    wr(tdg_pkg::ADDR_IRQ_MASK, 16'h0001);
    cmd(0, 2'h1, 1'b0);
    tick(40);
    enCmd <= 2'h1;
    tick(10);
    chk({10'h000, highGate, lowGate}, 16'h0000, "gates disabled");
    chk(16'(irq), 16'h0001, "irq on drop");
    enCmd <= 2'h3;
    tick(10);
    rd(tdg_pkg::ADDR_IRQ_STAT, 16'h000F, 16'h0001, "stat drop");
    wr(tdg_pkg::ADDR_IRQ_STAT, 16'h0001);
    tick(2);
    chk(16'(irq), 16'h0000, "irq cleared");
    cmd(1, 2'h2, 1'b1);
    tick(40);
    chk(16'(highGate[1]), 16'h0000, "high refused");
    rd(tdg_pkg::ADDR_IRQ_STAT, 16'h000F, 16'h0002, "stat refused");
    chk(16'(irq), 16'h0000, "masked source");
    cmd(1, 2'h0, 1'b0);
    cmd(0, 2'h0, 1'b0);
    $display("test enables done");
    wr(tdg_pkg::ADDR_SIMUL, 16'h0100);
    rd(tdg_pkg::ADDR_SIMUL, 16'h0102, 16'h0000, "no key");
    wr(tdg_pkg::ADDR_SIMUL, tdg_pkg::UNLOCK_KEY1);
    wr(tdg_pkg::ADDR_SIMUL, tdg_pkg::UNLOCK_KEY2);
    wr(tdg_pkg::ADDR_SIMUL, 16'h0000);
    rd(tdg_pkg::ADDR_SIMUL, 16'h0102, 16'h0002, "set once");
    wr(tdg_pkg::ADDR_SIMUL, tdg_pkg::UNLOCK_KEY1);
    wr(tdg_pkg::ADDR_SIMUL, tdg_pkg::UNLOCK_KEY2);
    wr(tdg_pkg::ADDR_SIMUL, 16'h0100);
    rd(tdg_pkg::ADDR_SIMUL, 16'h0102, 16'h0002, "second ignored");
    rd(tdg_pkg::ADDR_IRQ_STAT, 16'h0004, 16'h0004, "stat simul");
    wr(tdg_pkg::ADDR_CTRL, 16'h0008);
    wr(tdg_pkg::ADDR_CTRL, 16'h0001);
    rd(tdg_pkg::ADDR_CTRL, 16'h000F, 16'h0008, "locked");
    rd(tdg_pkg::ADDR_IRQ_STAT, 16'h0008, 16'h0008, "stat lock");
    $display("test modes done");
    // second reset frees the once-only setting; enables low keep the checker quiet
    rst_b <= 1'b0;
    tick(4);
    rst_b <= 1'b1;
    tick(8);
    wr(tdg_pkg::ADDR_SIMUL, tdg_pkg::UNLOCK_KEY1);
    wr(tdg_pkg::ADDR_SIMUL, tdg_pkg::UNLOCK_KEY2);
    wr(tdg_pkg::ADDR_SIMUL, 16'h0100);
    rd(tdg_pkg::ADDR_SIMUL, 16'h0102, 16'h0102, "simul on");
    enCmd <= 2'h0;
    tick(10);
    cmd(0, 2'h1, 1'b0);
    tick(10);
    chk({13'h0000, blank[0], lowGate[0], highGate[0]}, 16'h0000, "no blanking");
    cmd(0, 2'h0, 1'b0);
    enCmd <= 2'h3;
    tick(10);
    $display("test simul done");
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    $display("BAD %0t run too long", $time);
    failures++;
    end_of_test();
  end
endmodule
